// ==== src/serial_channel_buffer_control_mode.v ====
// Serial channel data port, line control and mode register zero with their shifters.
// Assumes an APB master on SYS_CLK; TIMER_OUT_CLK and BAUD_TICK are same-clock one-cycle pulses.
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "serial_channel_map.vh"
module serial_channel_buffer_control_mode #(
  parameter OS = `OVERSAMPLE
) (
  input  wire        SYS_CLK,
  input  wire        RST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [5:0]  PADDR,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire        TIMER_OUT_CLK,
  input  wire        BAUD_TICK,
  input  wire        RXD,
  input  wire        SCLK_CTS_IN,
  output wire        TXD,
  output wire        SCLK_OUT,
  output wire        SCLK_OE,
  output wire        RX_EVENT
);
  // Pin synchronisers, one per input pin
  wire [1:0] pin_in = {SCLK_CTS_IN, RXD};
  wire [1:0] pin_sync;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_sync
      reg [1:0] stage_reg;
      always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          stage_reg <= 2'h3;
        end else begin
          stage_reg <= {stage_reg[0], pin_in[g]};
        end
      end
      assign pin_sync[g] = stage_reg[1];
    end
  endgenerate
  wire       rxd_s  = pin_sync[0];
  wire       sclk_s = pin_sync[1];
  reg        sclk_prev_reg;
  wire       sclk_rise = sclk_s & ~sclk_prev_reg;
  wire       sclk_fall = ~sclk_s & sclk_prev_reg;

  // Register state
  reg        chan_en_reg;
  reg        even_reg;
  reg        par_en_reg;
  reg        edge_reg;
  reg        sync_src_reg;
  reg        overrun_reg;
  reg        par_und_reg;
  reg        framing_reg;
  reg        rx_ninth_reg;
  reg        tx_ninth_reg;
  reg        handshake_reg;
  reg        rx_enable_reg;
  reg        wake_reg;
  reg  [1:0] xfer_mode_reg;
  reg  [1:0] uart_clk_reg;
  reg  [7:0] tx_byte_reg;
  reg        tx_pend_reg;
  reg  [7:0] rx_byte_reg;
  reg        rx_full_reg;
  reg [31:0] prdata_reg;
  reg [31:0] prdata_next;
  reg        rx_event_reg;
  reg        io_run_reg;
  reg  [4:0] io_cnt_reg;
  reg        sclk_out_reg;

  // APB decode
  wire       setup    = PSEL & ~PENABLE;
  wire       access   = PSEL & PENABLE;
  wire       hit_en   = (PADDR == `CH_ENABLE_OFF);
  wire       hit_buf  = (PADDR == `DATA_PORT_OFF);
  wire       hit_lc   = (PADDR == `LINE_CONTROL_OFF);
  wire       hit_mz   = (PADDR == `MODE_ZERO_OFF);
  wire       mapped   = hit_en | hit_buf | hit_lc | hit_mz;
  wire       wr       = access & PWRITE;
  // Register writes other than the enable itself are dropped while disabled
  wire       wr_en    = wr & hit_en;
  wire       wr_buf   = wr & hit_buf & chan_en_reg;
  wire       wr_lc    = wr & hit_lc & chan_en_reg;
  wire       wr_mz    = wr & hit_mz & chan_en_reg;
  wire       rd_buf   = access & ~PWRITE & hit_buf & chan_en_reg;
  wire       rd_lc    = access & ~PWRITE & hit_lc & chan_en_reg;

  // Mode and clock selection
  wire       io_mode  = (xfer_mode_reg == `XFER_IO);
  wire       io_ext   = io_mode & sync_src_reg;
  wire       io_int   = io_mode & ~sync_src_reg;
  reg        src_tick;
  always @* begin
    case (uart_clk_reg)
      `UCLK_TIMER:    src_tick = TIMER_OUT_CLK;
      `UCLK_BAUD:     src_tick = BAUD_TICK;
      `UCLK_SYSTEM:   src_tick = 1'b1;
      `UCLK_EXTERNAL: src_tick = sclk_rise;
      default:        src_tick = 1'b0;
    endcase
  end
  // The UART clock field plays no part in I/O mode
  wire       os_tick   = src_tick & chan_en_reg & ~io_mode;
  // Driving the clock out always samples on its rising edge
  wire       ext_sample = chan_en_reg & io_ext & (edge_reg ? sclk_fall : sclk_rise);
  wire       ext_shift  = chan_en_reg & io_ext & (edge_reg ? sclk_rise : sclk_fall);
  wire       int_shift  = io_int & io_run_reg & BAUD_TICK & sclk_out_reg;
  wire       int_sample = io_int & io_run_reg & BAUD_TICK & ~sclk_out_reg;
  wire       io_shift   = io_ext ? ext_shift : int_shift;
  wire       io_sample  = io_ext ? ext_sample : int_sample;

  // Transmit side
  wire       tx_busy;
  // CTS is active low and only checked before a frame starts, never mid-frame
  wire       cts_ok   = io_mode | ~handshake_reg | ~sclk_s;
  wire       tx_start = chan_en_reg & tx_pend_reg & ~tx_busy & cts_ok &
                        ~(io_int & io_run_reg);
  wire       io_start = io_int & chan_en_reg & ~io_run_reg &
                        (tx_busy | (rx_enable_reg & ~rx_full_reg & ~tx_pend_reg));
  wire       underrun = ext_shift & ~tx_busy & ~tx_pend_reg & ~rx_enable_reg;

  serial_tx_engine #(
    .OS (OS)
  ) u_tx (
    .clk         (SYS_CLK),
    .rst_n       (RST_N),
    .start       (tx_start),
    .io_mode     (io_mode),
    .os_tick     (os_tick),
    .io_shift    (io_shift),
    .mode        (xfer_mode_reg),
    .parity_en   (par_en_reg),
    .parity_even (even_reg),
    .data        (tx_byte_reg),
    .ninth       (tx_ninth_reg),
    .busy        (tx_busy),
    .txd         (TXD)
  );

  // Receive side
  wire       rx_done;
  wire [7:0] rx_data;
  wire       rx_ninth;
  wire       rx_parity_underrun_flag;
  wire       rx_framing_flag;
  serial_rx_engine #(
    .OS (OS)
  ) u_rx (
    .clk         (SYS_CLK),
    .rst_n       (RST_N),
    .enable      (chan_en_reg & rx_enable_reg),
    .io_mode     (io_mode),
    .os_tick     (os_tick),
    .io_sample   (io_sample),
    .rxd         (rxd_s),
    .mode        (xfer_mode_reg),
    .parity_en   (par_en_reg),
    .parity_even (even_reg),
    .done        (rx_done),
    .data        (rx_data),
    .ninth       (rx_ninth),
    .parity_underrun_flag        (rx_parity_underrun_flag),
    .framing_flag        (rx_framing_flag)
  );
  // A byte that finds the buffer still unread is dropped and flagged
  wire       rx_accept  = rx_done & (~rx_full_reg | rd_buf);
  wire       overrun_set = rx_done & rx_full_reg & ~rd_buf;
  wire       wake_block = wake_reg & (xfer_mode_reg == `XFER_UART9) & ~rx_ninth;

  // Read data is captured in the setup phase so the clear acts only on what was seen
  always @* begin
    prdata_next = 32'h00000000;
    case (PADDR)
      `CH_ENABLE_OFF: prdata_next[0] = chan_en_reg;
      `DATA_PORT_OFF: prdata_next[7:0] = rx_byte_reg;
      `LINE_CONTROL_OFF: prdata_next[7:0] = {rx_ninth_reg, even_reg, par_en_reg,
                                             overrun_reg, par_und_reg, framing_reg,
                                             edge_reg, sync_src_reg};
      `MODE_ZERO_OFF: prdata_next[7:0] = {tx_ninth_reg, handshake_reg, rx_enable_reg,
                                          wake_reg, xfer_mode_reg, uart_clk_reg};
      default: prdata_next = 32'h00000000;
    endcase
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_prev_reg <= 1'b1;
      chan_en_reg   <= `CH_ENABLE_RST;
      {rx_ninth_reg, even_reg, par_en_reg, overrun_reg, par_und_reg, framing_reg,
       edge_reg, sync_src_reg} <= `LINE_CONTROL_RST;
      {tx_ninth_reg, handshake_reg, rx_enable_reg, wake_reg, xfer_mode_reg,
       uart_clk_reg} <= `MODE_ZERO_RST;
      tx_byte_reg   <= 8'h00;
      tx_pend_reg   <= 1'b0;
      rx_byte_reg   <= 8'h00;
      rx_full_reg   <= 1'b0;
      prdata_reg    <= 32'h00000000;
      rx_event_reg  <= 1'b0;
      io_run_reg    <= 1'b0;
      io_cnt_reg    <= 5'h00;
      sclk_out_reg  <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_s;
      if (setup && !PWRITE) prdata_reg <= prdata_next;
      if (wr_en) chan_en_reg <= PWDATA[0];
      if (wr_lc) begin
        even_reg     <= PWDATA[`LC_EVEN_BIT];
        par_en_reg   <= PWDATA[`LC_PAR_EN_BIT];
        edge_reg     <= PWDATA[`LC_EDGE_BIT];
        sync_src_reg <= PWDATA[`LC_SYNC_SRC_BIT];
      end
      if (wr_mz) begin
        tx_ninth_reg  <= PWDATA[`MZ_TX_NINTH_BIT];
        handshake_reg <= PWDATA[`MZ_HANDSHAKE_BIT];
        rx_enable_reg <= PWDATA[`MZ_RX_ENABLE_BIT];
        wake_reg      <= PWDATA[`MZ_WAKE_BIT];
        xfer_mode_reg <= PWDATA[`MZ_MODE_HI:`MZ_MODE_LO];
        uart_clk_reg  <= PWDATA[`MZ_CLK_HI:`MZ_CLK_LO];
      end
      // Error flags: a new event wins over the clear of the same cycle
      overrun_reg <= (overrun_reg & ~(rd_lc & prdata_reg[`LC_OVERRUN_BIT])) | overrun_set;
      par_und_reg <= (par_und_reg & ~(rd_lc & prdata_reg[`LC_PAR_UND_BIT])) |
                     (rx_done & rx_parity_underrun_flag) | underrun;
      framing_reg <= (framing_reg & ~(rd_lc & prdata_reg[`LC_FRAMING_BIT])) |
                     (rx_done & rx_framing_flag);
      // A second write before the byte left overwrites the pending one
      if (wr_buf) tx_byte_reg <= PWDATA[7:0];
      tx_pend_reg <= (tx_pend_reg & ~tx_start) | wr_buf;
      if (rx_accept) begin
        rx_byte_reg  <= rx_data;
        rx_ninth_reg <= rx_ninth;
      end
      rx_full_reg  <= (rx_full_reg & ~rd_buf) | rx_accept;
      rx_event_reg <= rx_accept & ~wake_block;
      // Generated I/O clock: sixteen toggles per byte, idle high
      if (io_start) begin
        io_run_reg <= 1'b1;
        io_cnt_reg <= 5'h00;
      end else if (!io_int || !chan_en_reg) begin
        io_run_reg   <= 1'b0;
        sclk_out_reg <= 1'b1;
      end else if (io_run_reg && BAUD_TICK) begin
        sclk_out_reg <= ~sclk_out_reg;
        io_cnt_reg   <= io_cnt_reg + 5'h01;
        if (io_cnt_reg == `IO_TOGGLES) io_run_reg <= 1'b0;
      end
    end
  end

  assign PRDATA   = prdata_reg;
  assign PREADY   = 1'b1;
  assign PSLVERR  = access & ~mapped;
  assign SCLK_OUT = sclk_out_reg;
  assign SCLK_OE  = io_int & chan_en_reg;
  assign RX_EVENT = rx_event_reg;
endmodule

// ==== src/serial_channel_map.vh ====
// Register offsets, field positions, reset values and timing counts of the serial channel.
// Included by every design file of the channel; definitions only.
`ifndef SERIAL_CHANNEL_MAP_VH
`define SERIAL_CHANNEL_MAP_VH
`define CH_ENABLE_OFF    6'h00
`define DATA_PORT_OFF    6'h04
`define LINE_CONTROL_OFF 6'h08
`define MODE_ZERO_OFF    6'h0C
`define LC_NINTH_BIT     7
`define LC_EVEN_BIT      6
`define LC_PAR_EN_BIT    5
`define LC_OVERRUN_BIT   4
`define LC_PAR_UND_BIT   3
`define LC_FRAMING_BIT   2
`define LC_EDGE_BIT      1
`define LC_SYNC_SRC_BIT  0
`define MZ_TX_NINTH_BIT  7
`define MZ_HANDSHAKE_BIT 6
`define MZ_RX_ENABLE_BIT 5
`define MZ_WAKE_BIT      4
`define MZ_MODE_HI       3
`define MZ_MODE_LO       2
`define MZ_CLK_HI        1
`define MZ_CLK_LO        0
`define XFER_IO          2'h0
`define XFER_UART7       2'h1
`define XFER_UART8       2'h2
`define XFER_UART9       2'h3
`define UCLK_TIMER       2'h0
`define UCLK_BAUD        2'h1
`define UCLK_SYSTEM      2'h2
`define UCLK_EXTERNAL    2'h3
`define CH_ENABLE_RST    1'h0
`define LINE_CONTROL_RST 8'h00
`define MODE_ZERO_RST    8'h00
`define OVERSAMPLE       16
`define IO_BITS          8
`define IO_TOGGLES       5'h0F
`endif

// ==== src/serial_rx_engine.v ====
// Receive shifter: UART frames sampled mid-bit on the oversampling tick, or LSB-first I/O bits.
// Assumes rxd is already synchronised; enable low aborts any partial frame.
`timescale 1ns/100ps
`include "serial_channel_map.vh"
module serial_rx_engine #(
  parameter OS = `OVERSAMPLE
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       enable,
  input  wire       io_mode,
  input  wire       os_tick,
  input  wire       io_sample,
  input  wire       rxd,
  input  wire [1:0] mode,
  input  wire       parity_en,
  input  wire       parity_even,
  output reg        done,
  output reg  [7:0] data,
  output reg        ninth,
  output reg        parity_underrun_flag,
  output reg        framing_flag
);
  reg  [10:0] sr_reg;
  reg  [3:0]  cnt_reg;
  reg  [3:0]  os_reg;
  reg         hunt_reg;
  reg         busy_reg;
  wire [3:0]  nbits = io_mode ? 4'h8 : (mode == `XFER_UART7) ? (parity_en ? 4'h9 : 4'h8) :
                      (mode == `XFER_UART8 && !parity_en) ? 4'h9 : 4'hA;
  wire [10:0] word = {rxd, sr_reg[10:1]} >> (4'hB - nbits);
  wire        last = (cnt_reg == nbits - 4'h1);
  wire        take = io_mode ? (busy_reg & io_sample) :
                     (busy_reg & !hunt_reg & os_tick & (os_reg == OS - 1));
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_reg <= 11'h000; cnt_reg <= 4'h0; os_reg <= 4'h0;
      hunt_reg <= 1'b0; busy_reg <= 1'b0;
      done <= 1'b0; data <= 8'h00; ninth <= 1'b0; parity_underrun_flag <= 1'b0; framing_flag <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!enable) begin
        busy_reg <= 1'b0;
      end else if (!busy_reg) begin
        cnt_reg <= 4'h0;
        os_reg  <= 4'h0;
        if (io_mode || (os_tick && !rxd)) begin
          busy_reg <= 1'b1;
          hunt_reg <= !io_mode;
        end
      end else if (hunt_reg) begin
        if (os_tick) os_reg <= os_reg + 4'h1;
        // A start bit that is high again at mid-bit was a glitch
        if (os_tick && os_reg == OS / 2 - 1) begin
          hunt_reg <= 1'b0;
          busy_reg <= !rxd;
          os_reg   <= 4'h0;
        end
      end else begin
        if (os_tick) os_reg <= (os_reg == OS - 1) ? 4'h0 : os_reg + 4'h1;
        if (take) begin
          sr_reg  <= {rxd, sr_reg[10:1]};
          cnt_reg <= cnt_reg + 4'h1;
          if (last) begin
            busy_reg <= 1'b0;
            done     <= 1'b1;
            data     <= (mode == `XFER_UART7 && !io_mode) ? {1'b0, word[6:0]} : word[7:0];
            ninth    <= !io_mode && mode == `XFER_UART9 && word[8];
            framing_flag     <= !io_mode && !rxd;
            parity_underrun_flag     <= !io_mode && parity_en &&
                        ((mode == `XFER_UART7 && word[7] != (^word[6:0] ^ ~parity_even)) ||
                         (mode == `XFER_UART8 && word[8] != (^word[7:0] ^ ~parity_even)));
          end
        end
      end
    end
  end
endmodule

// ==== src/serial_tx_engine.v ====
// Transmit shifter: UART frames on the oversampling tick, or LSB-first I/O bits on shift pulses.
// Assumes ticks and pulses are one-cycle strobes from the same clock.
`timescale 1ns/100ps
`include "serial_channel_map.vh"
module serial_tx_engine #(
  parameter OS = `OVERSAMPLE
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       start,
  input  wire       io_mode,
  input  wire       os_tick,
  input  wire       io_shift,
  input  wire [1:0] mode,
  input  wire       parity_en,
  input  wire       parity_even,
  input  wire [7:0] data,
  input  wire       ninth,
  output wire       busy,
  output wire       txd
);
  reg  [10:0] sr_reg;
  reg  [3:0]  bits_reg;
  reg  [3:0]  os_reg;
  reg         busy_reg;
  reg         txd_reg;
  reg  [10:0] frame;
  reg  [3:0]  nbits;
  wire        par7 = ^data[6:0] ^ ~parity_even;
  wire        par8 = ^data ^ ~parity_even;
  wire        bit_end = os_tick & (os_reg == OS - 1);
  always @* begin
    frame = 11'h7FF;
    nbits = 4'h0;
    case (mode)
      `XFER_UART7: begin
        frame = parity_en ? {3'h7, par7, data[6:0]} : {4'hF, data[6:0]};
        nbits = parity_en ? 4'h9 : 4'h8;
      end
      `XFER_UART8: begin
        frame = parity_en ? {2'h3, par8, data} : {3'h7, data};
        nbits = parity_en ? 4'hA : 4'h9;
      end
      `XFER_UART9: begin
        frame = {2'h3, ninth, data};
        nbits = 4'hA;
      end
      default: begin
        frame = {3'h7, data};
        nbits = 4'h8;
      end
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_reg   <= 11'h7FF;
      bits_reg <= 4'h0;
      os_reg   <= 4'h0;
      busy_reg <= 1'b0;
      txd_reg  <= 1'b1;
    end else if (start && !busy_reg) begin
      sr_reg   <= frame;
      bits_reg <= nbits;
      os_reg   <= 4'h0;
      busy_reg <= 1'b1;
      if (!io_mode) txd_reg <= 1'b0;
    end else if (busy_reg && io_mode) begin
      if (io_shift) begin
        txd_reg  <= sr_reg[0];
        sr_reg   <= {1'b1, sr_reg[10:1]};
        bits_reg <= bits_reg - 4'h1;
        busy_reg <= (bits_reg != 4'h1);
      end
    end else if (busy_reg) begin
      if (os_tick) os_reg <= (os_reg == OS - 1) ? 4'h0 : os_reg + 4'h1;
      if (bit_end) begin
        // The stop bit lasts a whole bit time before the shifter frees up
        if (bits_reg == 4'h0) begin
          busy_reg <= 1'b0;
        end else begin
          txd_reg  <= sr_reg[0];
          sr_reg   <= {1'b1, sr_reg[10:1]};
          bits_reg <= bits_reg - 4'h1;
        end
      end
    end
  end
  assign busy = busy_reg;
  assign txd  = txd_reg;
endmodule

// ==== test/serial_channel_props.sv ====
// Checker for the serial channel register port and line pins.
// Bound into the channel top; sees its ports only, one clock domain.
`timescale 1ns/100ps
module serial_channel_props #(
  parameter OS = 16
) (
  input wire        SYS_CLK,
  input wire        RST_N,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [5:0]  PADDR,
  input wire [31:0] PRDATA,
  input wire        PSLVERR,
  input wire        TXD,
  input wire        SCLK_OUT,
  input wire        SCLK_OE,
  input wire        RX_EVENT
);
  reg [11:0] low_run;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence lc_setup;
    PSEL && !PENABLE && !PWRITE && PADDR == 6'h08;
  endsequence
  sequence lc_read;
    lc_setup ##1 PSEL && PENABLE;
  endsequence
  // Longest legal low run: start bit plus nine zero bits
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_run <= 12'h000;
    end else begin
      low_run <= TXD ? 12'h000 : low_run + 12'h001;
    end
  end
  AST_UNMAPPED: assert property (PSEL && PENABLE &&
                                 (PADDR > 6'h0C || PADDR[1:0] != 2'h0) |-> PSLVERR)
    else $error("unmapped access without error response");
  AST_MAPPED_OK: assert property (PSEL && PENABLE &&
                                  PADDR <= 6'h0C && PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("mapped access flagged as error");
  AST_UPPER_ZERO: assert property (PRDATA[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  AST_PRDATA_HOLD: assert property (PSEL && PENABLE |=> $stable(PRDATA))
    else $error("read data moved after access");
  AST_CLEAR_ON_READ: assert property (lc_read ##2 lc_setup |=> PRDATA[4:2] == 3'h0)
    else $error("error flags survived a line control read");
  AST_RX_PULSE: assert property (RX_EVENT |=> !RX_EVENT)
    else $error("receive event wider than one cycle");
  AST_START_BIT: assert property ($fell(TXD) |-> (!TXD) [*8])
    else $error("start bit shorter than half a bit");
  AST_SCLK_IDLE: assert property (!SCLK_OE |-> SCLK_OUT)
    else $error("clock pin low while not driven");
  AST_TX_LOW_RUN: assert property (low_run <= 10 * OS)
    else $error("transmit line low longer than a frame");
endmodule
bind serial_channel_buffer_control_mode serial_channel_props #(.OS(OS)) u_props (.*);

// ==== test/serial_peer.sv ====
// Serial peer: drives the receive line and handshake pin, samples the transmit line.
// Assumes the system-clock source, so one bit lasts 16 clocks.
`timescale 1ns/100ps
module serial_peer (
  input  wire clk,
  input  wire txd,
  output reg  rxd,
  output reg  cts_n
);
  reg [10:0] cap;
  initial begin
    rxd   = 1'b1;
    cts_n = 1'b0;
    cap   = 11'h000;
  end
  // Last bit cut short so a low stop bit cannot pose as a new start
  task send(input [10:0] bits, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk);
        rxd <= bits[i];
        repeat ((i == n - 1) ? 12 : 15) @(posedge clk);
      end
      @(posedge clk);
      rxd <= 1'b1;
      repeat (20) @(posedge clk);
    end
  endtask
  task set_cts(input v);
    begin
      @(posedge clk);
      cts_n <= v;
    end
  endtask
  // Clocks n I/O bits on the shared pin, idle high; txd is taken at each rising edge
  task clock_io(input integer n);
    integer i;
    begin
      cap = 11'h000;
      for (i = 0; i < n; i = i + 1) begin
        repeat (8) @(posedge clk);
        cts_n <= 1'b0;
        repeat (8) @(posedge clk);
        cts_n <= 1'b1;
        cap[i] = txd;
      end
    end
  endtask
  // Samples mid-bit, skipping the start bit
  task capture(input integer n);
    integer i;
    begin
      cap = 11'h000;
      @(negedge txd);
      repeat (24) @(posedge clk);
      for (i = 0; i < n; i = i + 1) begin
        cap[i] = txd;
        repeat (16) @(posedge clk);
      end
    end
  endtask
endmodule

// ==== test/tb_top.sv ====
// Testbench for the serial channel: APB master, serial peer, scenario tasks.
// Assumes the system-clock UART source; timer and baud pulses are held off.
`timescale 1ns/100ps
module tb_top;
  reg         sys_clk;
  reg         rst_n;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [5:0]  paddr;
  reg  [31:0] pwdata;
  reg  [31:0] rd;
  reg         err;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        txd;
  wire        rxd;
  wire        cts_n;
  wire        rx_event;
  wire        sclk_oe;
  integer     n_errors;
  integer     checked;
  integer     cycles = 0;
  serial_channel_buffer_control_mode dut (
    .SYS_CLK       (sys_clk),
    .RST_N         (rst_n),
    .PSEL          (psel),
    .PENABLE       (penable),
    .PWRITE        (pwrite),
    .PADDR         (paddr),
    .PWDATA        (pwdata),
    .PRDATA        (prdata),
    .PREADY        (pready),
    .PSLVERR       (pslverr),
    .TIMER_OUT_CLK (1'b0),
    .BAUD_TICK     (1'b0),
    .RXD           (rxd),
    .SCLK_CTS_IN   (cts_n),
    .TXD           (txd),
    .SCLK_OUT      (),
    .SCLK_OE       (sclk_oe),
    .RX_EVENT      (rx_event)
  );
  serial_peer peer (
    .clk   (sys_clk),
    .txd   (txd),
    .rxd   (rxd),
    .cts_n (cts_n)
  );
  always #25 sys_clk = ~sys_clk;
  task close_out;
    begin
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      close_out;
    end
  end
  task cmp(input [8*8:1] what, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Waits for pready rather than assuming zero wait states
  task apb(input w, input [5:0] a, input [31:0] d, output [31:0] q);
    begin
      @(posedge sys_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) begin
        @(posedge sys_clk);
      end
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [5:0] a, input [31:0] d);
    apb(1'b1, a, d, rd);
  endtask
  task rdc(input [5:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0, rd);
      cmp("rdata", e, rd);
    end
  endtask
  task wait_ev(input e);
    integer n;
    reg     seen;
    begin
      seen = 1'b0;
      for (n = 0; n < 260; n = n + 1) begin
        // Looked at between edges, where the registered pulse has settled
        @(negedge sys_clk);
        if (rx_event === 1'b1) seen = 1'b1;
      end
      cmp("rx_event", {31'h0, e}, {31'h0, seen});
    end
  endtask
  task rx_frame(input [10:0] bits, input integer n, input e);
    fork
      peer.send(bits, n);
      wait_ev(e);
    join
  endtask
  task t_reset;
    begin
      rdc(6'h04, 32'h0);
      rdc(6'h08, 32'h0);
      rdc(6'h0C, 32'h0);
      apb(1'b0, 6'h10, 32'h0, rd);
      cmp("slverr", 32'h1, {31'h0, err});
      cmp("unmapped", 32'h0, rd);
    end
  endtask
  task t_enable;
    begin
      wr(6'h0C, 32'h0A);
      rdc(6'h0C, 32'h0);
      wr(6'h00, 32'h1);
      rdc(6'h00, 32'h1);
      wr(6'h0C, 32'h0A);
      rdc(6'h0C, 32'h0A);
      wr(6'h08, 32'hFF);
      rdc(6'h08, 32'h63);
      wr(6'h00, 32'h0);
      wr(6'h0C, 32'h55);
      rdc(6'h0C, 32'h0A);
      wr(6'h00, 32'h1);
    end
  endtask
  task t_tx(input [7:0] m0, input [7:0] lc, input [7:0] d, input [10:0] f, input integer n);
    begin
      wr(6'h08, {24'h0, lc});
      wr(6'h0C, {24'h0, m0});
      fork
        peer.capture(n);
        wr(6'h04, {24'h0, d});
      join
      cmp("frame", {21'h0, f}, {21'h0, peer.cap});
    end
  endtask
  // Held byte must wait for the handshake pin
  task t_cts;
    begin
      peer.set_cts(1'b1);
      wr(6'h08, 32'h0);
      wr(6'h0C, 32'h4A);
      fork
        peer.capture(9);
        begin
          wr(6'h04, 32'h5A);
          repeat (40) @(posedge sys_clk);
          cmp("txd", 32'h1, {31'h0, txd});
          peer.set_cts(1'b0);
        end
      join
      cmp("frame", 32'h15A, {21'h0, peer.cap});
    end
  endtask
  task t_rx;
    begin
      wr(6'h0C, 32'h0A);
      wr(6'h0C, 32'h2A);
      rx_frame(11'h278, 10, 1'b1);
      rdc(6'h04, 32'h3C);
      rx_frame(11'h222, 10, 1'b1);
      peer.send(11'h244, 10);
      rdc(6'h08, 32'h10);
      rdc(6'h08, 32'h0);
      rdc(6'h04, 32'h11);
      peer.send(11'h0AA, 10);
      rdc(6'h08, 32'h04);
      apb(1'b0, 6'h04, 32'h0, rd);
      wr(6'h08, 32'h60);
      peer.send(11'h402, 11);
      rdc(6'h08, 32'h68);
      apb(1'b0, 6'h04, 32'h0, rd);
      wr(6'h0C, 32'h0A);
    end
  endtask
  task t_nine;
    begin
      wr(6'h08, 32'h0);
      wr(6'h0C, 32'h1E);
      wr(6'h0C, 32'h3E);
      rx_frame(11'h4EE, 11, 1'b0);
      rdc(6'h04, 32'h77);
      rx_frame(11'h710, 11, 1'b1);
      rdc(6'h08, 32'h80);
      rdc(6'h04, 32'h88);
    end
  endtask
  // Pin-clocked I/O byte; a ninth pulse with nothing to send is an underrun
  task t_io;
    begin
      peer.set_cts(1'b1);
      wr(6'h08, 32'h01);
      wr(6'h0C, 32'h00);
      wr(6'h04, 32'hA5);
      peer.clock_io(9);
      cmp("io_frame", 32'h1A5, {21'h0, peer.cap});
      cmp("sclk_oe", 32'h0, {31'h0, sclk_oe});
      rdc(6'h08, 32'h89);
      wr(6'h08, 32'h00);
      @(negedge sys_clk);
      cmp("sclk_oe", 32'h1, {31'h0, sclk_oe});
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 6'h00;
    pwdata = 32'h0;
    n_errors = 0;
    checked = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset;
    t_enable;
    t_tx(8'h0A, 8'h60, 8'hA5, 11'h2A5, 10);
    t_tx(8'h0A, 8'h20, 8'hA5, 11'h3A5, 10);
    t_tx(8'h06, 8'h00, 8'h31, 11'h0B1, 8);
    t_tx(8'h06, 8'h60, 8'h31, 11'h1B1, 9);
    t_tx(8'h8E, 8'h60, 8'h00, 11'h300, 10);
    t_cts;
    t_rx;
    t_nine;
    t_io;
    close_out;
  end
endmodule
